// file: sae_encoder_port.sv
/*
 Serial position port of a single-turn absolute encoder. The master sends
 a clock burst; the port captures the position word on the first falling
 edge, shifts it MSB first on rising edges, then holds the line low for the
 monoflop time. With 13-bit words, a clock that keeps running repeats the captured word.
 Assumes: the position and special bit come from logic on i_sys_clk; the
 direction and variant pins are asynchronous; the link clock runs no faster
 than 2 MBaud, so each half period is far longer than the edge-sync delay.
*/
`timescale 1ns/1ps
// Notes on behaviour
// RQ1: Idle data line high, master clock high.
// RQ2: First falling edge captures position and special.
// RQ3: First rising edge presents the MSB.
// RQ4: Each later rising edge sends next bit.
// RQ5: After LSB, data low until monoflop ends.
// RQ6: Master waits for data high before bursting.
// RQ7: Monoflop restarts on every falling clock edge.
// RQ8: Monoflop is 20 us; clock periods shorter.
// RQ9: Master clock at most 2 MBaud.
// RQ10: Continued clock repeats the same captured word.
// RQ11: Each word spans 25 clock bits.
// RQ12: Pulse 26 late means fresh word captured.
// RQ13: Repetition only for words of 13 bits.
// RQ14: Position word has 16 bits per turn.
// RQ15: Gray or binary output per variant.
// RQ16: Default code falls with clockwise rotation.
// RQ17: Direction input low reverses counting direction.
// RQ18: Direction change effective within 10 ms.
// RQ19: Bits returned synchronous to master clock.
// RQ20: Master samples on falling edge, counts bits.
module sae_encoder_port
	import sae_pkg::*;
#(
	parameter logic [DIR_CNT_W-1:0] DIR_SETTLE_CYC = DIR_CNT_W'(DIR_SETTLE_CYC_DEF)
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_ssi_clk,
	input wire logic [POS_BITS-1:0] i_raw_pos,
	input wire logic i_special,
	input wire logic i_dir_sel_n,
	input wire logic i_gray_sel,
	input wire logic i_short_word,
	output logic o_ssi_data,
	output logic o_xfer_active,
	output logic o_dir_reversed
);

	sae_link_if u_lnk_if();

	sae_link_edges u_edges (
		.i_link_clk(i_ssi_clk),
		.lnk(u_lnk_if.link)
	);

	// Pin synchronisers
	logic [1:0] dir_sync_q;
	logic [1:0] gray_sync_q;
	logic [1:0] short_sync_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			dir_sync_q <= SYNC_HI;
			gray_sync_q <= SYNC_LO;
			short_sync_q <= SYNC_LO;
		end else if (i_clk_en) begin
			dir_sync_q <= {dir_sync_q[0], i_dir_sel_n};
			gray_sync_q <= {gray_sync_q[0], i_gray_sel};
			short_sync_q <= {short_sync_q[0], i_short_word};
		end
	end

	// Direction select: a new level must stand for the settle window
	// before it is taken, so a bouncing wire cannot flip the code mid-read.
	logic dir_pin_q;
	logic [DIR_CNT_W-1:0] dir_cnt_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			dir_pin_q <= DIR_PIN_IDLE;
			dir_cnt_q <= DIR_CNT_ZERO;
		end else if (i_clk_en) begin
			if (dir_sync_q[1] == dir_pin_q) begin
				dir_cnt_q <= DIR_CNT_ZERO;
			end else if (dir_cnt_q >= DIR_SETTLE_CYC - DIR_CNT_STEP) begin
				dir_pin_q <= dir_sync_q[1]; // [RQ18]
				dir_cnt_q <= DIR_CNT_ZERO;
			end else begin
				dir_cnt_q <= dir_cnt_q + DIR_CNT_STEP;
			end
		end
	end

	// Position code. The sensed count rises clockwise, so the default
	// output is its complement; an asserted (low) select passes it as is.
	logic [POS_BITS-1:0] pos_dir;
	logic [POS_BITS-1:0] pos_code;
	logic [FRAME_BITS-1:0] frame_next_q;

	always_comb begin
		if (dir_pin_q) begin
			pos_dir = ~i_raw_pos; // [RQ16] [RQ14]
		end else begin
			pos_dir = i_raw_pos; // [RQ17]
		end
		if (gray_sync_q[1]) begin
			pos_code = sae_bin2gray(pos_dir); // [RQ15]
		end else begin
			pos_code = pos_dir;
		end
	end

	// The next word is rebuilt every enabled cycle; the frame logic samples it once
	// per fresh transfer, so the position may move freely in between.
	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			frame_next_q <= FRAME_ZERO;
		end else if (i_clk_en) begin
			frame_next_q <= sae_build_frame(pos_code, i_special, short_sync_q[1]); // [RQ11]
		end
	end

	// Link edge events: two flip-flops per toggle, a third for the edge.
	// The resulting delay of about three cycles is small against a link
	// half period of at least 250 ns.
	logic [2:0] fall_sync_q;
	logic [2:0] rise_sync_q;
	logic fall_ev;
	logic rise_ev;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			fall_sync_q <= EDGE_SYNC_INIT;
			rise_sync_q <= EDGE_SYNC_INIT;
		end else if (i_clk_en) begin
			fall_sync_q <= {fall_sync_q[1:0], u_lnk_if.fall_tgl};
			rise_sync_q <= {rise_sync_q[1:0], u_lnk_if.rise_tgl};
		end
	end

	assign fall_ev = fall_sync_q[2] ^ fall_sync_q[1];
	assign rise_ev = rise_sync_q[2] ^ rise_sync_q[1];

	// Monoflop: loaded on every falling edge, so it times out only after
	// the last falling edge of a burst.
	logic [MONO_W-1:0] mono_cnt_q;
	logic mono_run;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			mono_cnt_q <= MONO_ZERO;
		end else if (i_clk_en) begin
			if (fall_ev) begin
				mono_cnt_q <= MONO_LOAD; // [RQ7] [RQ8]
			end else if (mono_cnt_q != MONO_ZERO) begin
				mono_cnt_q <= mono_cnt_q - MONO_STEP;
			end
		end
	end

	assign mono_run = (mono_cnt_q != MONO_ZERO);

	// Frame control
	sae_state_t state_q;
	logic [FRAME_BITS-1:0] shift_q;
	logic [BIT_CNT_W-1:0] bit_cnt_q;
	logic ring_ok_q;
	logic data_q;

	always_ff @(posedge i_sys_clk) begin
		if (!i_rst_n) begin
			state_q <= ST_IDLE;
			shift_q <= FRAME_ZERO;
			bit_cnt_q <= BIT_CNT_ZERO;
			ring_ok_q <= 1'b0;
			data_q <= LINE_IDLE;
		end else if (i_clk_en) begin
			case (state_q)
				ST_IDLE: begin
					data_q <= LINE_IDLE; // [RQ1]
					// Any falling edge here comes after the monoflop has run
					// out, so it always opens a fresh transfer.
					if (fall_ev) begin
						shift_q <= frame_next_q; // [RQ2] [RQ12]
						ring_ok_q <= short_sync_q[1]; // [RQ13]
						bit_cnt_q <= BIT_CNT_ZERO;
						state_q <= ST_SHIFT;
					end
				end
				ST_SHIFT: begin
					if (!mono_run && !fall_ev) begin
						// Clock too slow for the monoflop: the word is dropped
						// and the line released.
						data_q <= LINE_IDLE;
						state_q <= ST_IDLE;
					end else if (rise_ev) begin
						if (bit_cnt_q != BIT_CNT_LAST) begin
							// Rotating keeps the captured word for a repeat
							data_q <= shift_q[FRAME_MSB]; // [RQ3] [RQ4] [RQ19]
							shift_q <= {shift_q[FRAME_MSB-1:0], shift_q[FRAME_MSB]};
							bit_cnt_q <= bit_cnt_q + BIT_CNT_ONE;
						end else if (ring_ok_q) begin
							// Pulse 26 inside the monoflop: same word again
							data_q <= shift_q[FRAME_MSB]; // [RQ10] [RQ12]
							shift_q <= {shift_q[FRAME_MSB-1:0], shift_q[FRAME_MSB]};
							bit_cnt_q <= BIT_CNT_ONE;
						end else begin
							data_q <= LINE_LOW; // [RQ5] [RQ13]
							state_q <= ST_TAIL;
						end
					end
				end
				ST_TAIL: begin
					// Further edges only retrigger the monoflop
					if (!mono_run && !fall_ev) begin
						data_q <= LINE_IDLE; // [RQ5] [RQ1]
						state_q <= ST_IDLE;
					end else begin
						data_q <= LINE_LOW;
					end
				end
				default: begin
					data_q <= LINE_IDLE;
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	assign o_ssi_data = data_q;
	assign o_xfer_active = (state_q != ST_IDLE);
	assign o_dir_reversed = ~dir_pin_q;

endmodule

// file: sae_link_edges.sv
/*
 Link-clock logic: turns each falling and each rising edge of the master's
 clock into a toggle for the system-clock core.
 Assumes the link clock may stand still between bursts; no reset reaches
 this domain, so the toggles start from their declared value.
*/
`timescale 1ns/1ps
module sae_link_edges
	import sae_pkg::*;
(
	input wire logic i_link_clk,
	sae_link_if.link lnk
);

	logic fall_tgl_q = TGL_INIT;
	logic rise_tgl_q = TGL_INIT;

	// Each falling edge starts or retriggers the monoflop in the core
	always_ff @(negedge i_link_clk) begin
		fall_tgl_q <= ~fall_tgl_q; // [RQ7]
	end

	// Each rising edge launches the next bit in the core
	always_ff @(posedge i_link_clk) begin
		rise_tgl_q <= ~rise_tgl_q; // [RQ19]
	end

	assign lnk.fall_tgl = fall_tgl_q;
	assign lnk.rise_tgl = rise_tgl_q;

endmodule

// file: sae_link_if.sv
/*
 Edge events of the link clock, carried from the link-clock logic to the
 system-clock core as toggles.
 Assumes the receiving side synchronises each toggle with two flip-flops.
*/
`timescale 1ns/1ps
interface sae_link_if;
	logic fall_tgl;
	logic rise_tgl;
	modport link (output fall_tgl, output rise_tgl);
	modport core (input fall_tgl, input rise_tgl);
endinterface

// file: sae_pkg.sv
/*
 Constants, types and helper functions shared by the serial position port
 of the single-turn absolute encoder.
 Assumes a 200 MHz system clock and a link clock driven by the master.
*/
package sae_pkg;

	// System clock rate
	localparam int unsigned SYS_CLK_MHZ = 200;
	localparam int unsigned NS_PER_US = 1000;

	// Word layout
	localparam int unsigned POS_BITS = 16;
	localparam int unsigned RING_MAX_BITS = 13;
	localparam int unsigned POS_DROP_BITS = POS_BITS - RING_MAX_BITS;
	localparam int unsigned FRAME_BITS = 25;
	localparam int unsigned LEAD16_BITS = FRAME_BITS - POS_BITS - 1;
	localparam int unsigned LEAD13_BITS = FRAME_BITS - RING_MAX_BITS - 1;
	localparam int unsigned FRAME_MSB = FRAME_BITS - 1;

	// Bit counter over one frame; the value FRAME_BITS means the LSB is out
	localparam int unsigned BIT_CNT_W = 5;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ZERO = 5'h00;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_ONE = 5'h01;
	localparam logic [BIT_CNT_W-1:0] BIT_CNT_LAST = BIT_CNT_W'(FRAME_BITS);

	// Monoflop time, nominal figure of the 20 +/- 10 us window
	localparam int unsigned MONO_TIME_NS = 20000;
	localparam int unsigned MONO_CYC = (MONO_TIME_NS * SYS_CLK_MHZ) / NS_PER_US;
	localparam int unsigned MONO_W = 12;
	localparam logic [MONO_W-1:0] MONO_LOAD = MONO_W'(MONO_CYC);
	localparam logic [MONO_W-1:0] MONO_ZERO = 12'h000;
	localparam logic [MONO_W-1:0] MONO_STEP = 12'h001;

	// Direction input settle window, far inside the 10 ms allowance
	localparam int unsigned DIR_SETTLE_US = 1000;
	localparam int unsigned DIR_SETTLE_CYC_DEF = DIR_SETTLE_US * SYS_CLK_MHZ;
	localparam int unsigned DIR_CNT_W = 18;
	localparam logic [DIR_CNT_W-1:0] DIR_CNT_ZERO = 18'h00000;
	localparam logic [DIR_CNT_W-1:0] DIR_CNT_STEP = 18'h00001;

	// Reset and idle values
	localparam logic LINE_IDLE = 1'b1;
	localparam logic LINE_LOW = 1'b0;
	localparam logic DIR_PIN_IDLE = 1'b1;
	localparam logic TGL_INIT = 1'b0;
	localparam logic [1:0] SYNC_HI = 2'h3;
	localparam logic [1:0] SYNC_LO = 2'h0;
	localparam logic [2:0] EDGE_SYNC_INIT = 3'h0;
	localparam logic [FRAME_BITS-1:0] FRAME_ZERO = 25'h0000000;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_SHIFT = 3'b010,
		ST_TAIL = 3'b100
	} sae_state_t;

	function automatic logic [POS_BITS-1:0] sae_bin2gray(input logic [POS_BITS-1:0] b);
		sae_bin2gray = b ^ (b >> 1);
	endfunction

	// Leading zeros, position MSB first, special bit last
	function automatic logic [FRAME_BITS-1:0] sae_build_frame(
		input logic [POS_BITS-1:0] pos,
		input logic special,
		input logic short_word
	);
		if (short_word) begin
			sae_build_frame = {{LEAD13_BITS{1'b0}}, pos[POS_BITS-1:POS_DROP_BITS], special};
		end else begin
			sae_build_frame = {{LEAD16_BITS{1'b0}}, pos, special};
		end
	endfunction

endpackage

// file: sae_port_chk.sv
/*
 Checker for the encoder serial port, bound to every sae_encoder_port.
 Assumes the master clock stays far slower than the edge synchronisers.
*/
`timescale 1ns/1ps
module sae_port_chk
	import sae_pkg::*;
#(
	parameter logic [DIR_CNT_W-1:0] DIR_SETTLE_CYC = DIR_CNT_W'(DIR_SETTLE_CYC_DEF)
) (
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_clk_en,
	input wire logic i_ssi_clk,
	input wire logic i_dir_sel_n,
	input wire logic o_ssi_data,
	input wire logic o_xfer_active,
	input wire logic o_dir_reversed
);
	localparam int DIR_LIM = int'(DIR_SETTLE_CYC) + 8;
	int fall_q;
	int rise_q;
	int dir_q;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);
	// Cycles since the last falling and rising link edge, saturating.
	// The monoflop only runs on enabled cycles, so only those are counted for the falling edge.
	always_ff @(posedge i_sys_clk) begin
		fall_q <= !i_rst_n ? 9999 : $fell(i_ssi_clk) ? 0 :
			fall_q + int'(i_clk_en && fall_q < 9999);
	end
	always_ff @(posedge i_sys_clk) begin
		rise_q <= !i_rst_n ? 99 : $rose(i_ssi_clk) ? 0 : rise_q + int'(rise_q < 99);
	end
	always_ff @(posedge i_sys_clk) begin
		dir_q <= (!i_rst_n || $changed(i_dir_sel_n)) ? 0 : dir_q + int'(dir_q <= DIR_LIM);
	end
	a_reset_state: assert property (
		$rose(i_rst_n) |-> o_ssi_data && !o_xfer_active && !o_dir_reversed
	) else $error("outputs wrong after reset");
	a_idle_line_high: assert property (
		!o_xfer_active && !$past(o_xfer_active) && !$past(o_xfer_active, 2) |-> o_ssi_data
	) else $error("data low while idle");
	a_start_on_fall: assert property (
		$fell(i_ssi_clk) && !o_xfer_active |-> ##[1:5] o_xfer_active
	) else $error("falling edge did not start a transfer");
	a_start_from_fall: assert property (
		$rose(o_xfer_active) |-> fall_q <= 4 && o_ssi_data
	) else $error("transfer began without a falling edge");
	a_data_on_rise: assert property (
		$changed(o_ssi_data) && $past(o_xfer_active) && fall_q < 3900 |-> rise_q <= 6
	) else $error("data moved away from a rising edge");
	a_mono_hold: assert property (
		o_xfer_active && fall_q < 3990 |=> o_xfer_active
	) else $error("transfer ended before monoflop time");
	a_mono_end: assert property (
		fall_q == 4010 |-> !o_xfer_active && o_ssi_data
	) else $error("monoflop outlasted its time");
	a_dir_follow: assert property (
		dir_q == DIR_LIM |-> o_dir_reversed == !i_dir_sel_n
	) else $error("direction select not in force");
endmodule
bind sae_encoder_port sae_port_chk #(.DIR_SETTLE_CYC(DIR_SETTLE_CYC)) chk (
	.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en), .i_ssi_clk(i_ssi_clk),
	.i_dir_sel_n(i_dir_sel_n), .o_ssi_data(o_ssi_data),
	.o_xfer_active(o_xfer_active), .o_dir_reversed(o_dir_reversed)
);

// file: sae_ssi_master.sv
/*
 Model of the master controller: clock bursts, data read per bit.
 Assumes the bench calls burst only after the encoder left reset.
*/
`timescale 1ns/1ps
module sae_ssi_master #(
	parameter real HALF_NS = 250.3
) (
	input wire logic i_ssi_data,
	output logic o_ssi_clk
);
	initial o_ssi_clk = 1'h1; // Clock stands high outside bursts
	// Half period just over 250 ns: under 2 MBaud, drifting against i_sys_clk
	task automatic burst(input int n, input bit wait_idle, output logic [63:0] q);
		q = '0;
		#1.3;
		if (wait_idle) begin
			repeat (500) if (i_ssi_data !== 1'h1) #(HALF_NS);
		end
		for (int i = 0; i < n; i++) begin
			o_ssi_clk = 1'h0;
			#(HALF_NS);
			o_ssi_clk = 1'h1;
			#(HALF_NS);
			q = {q[62:0], i_ssi_data}; // Read at the falling edge that follows
		end
	endtask
endmodule

// file: tb_top.sv
/*
 Self-checking bench for the encoder serial port with a master model.
 Assumes a short direction settle count; clock enable is dropped once, in a tail.
*/
`timescale 1ns/1ps
module tb_top;
	import sae_pkg::*;
	typedef struct packed {
		logic [15:0] raw; logic s; logic dn; logic g; logic sh; logic rev;
	} sae_tb_row_t;
	sae_tb_row_t rows [5] = '{'{16'h1234, 1'h1, 1'h1, 1'h0, 1'h0, 1'h0},
		'{16'hA5C3, 1'h0, 1'h1, 1'h1, 1'h0, 1'h0}, '{16'h0F0F, 1'h1, 1'h0, 1'h0, 1'h0, 1'h1},
		'{16'hFFFF, 1'h0, 1'h0, 1'h1, 1'h1, 1'h1}, '{16'h8001, 1'h1, 1'h1, 1'h0, 1'h1, 1'h0}};
	logic sys_clk = 1'h0;
	logic rst_n = 1'h0;
	logic [15:0] raw_pos = 16'h0000;
	logic special = 1'h0;
	logic dir_sel_n = 1'h1;
	logic gray_sel = 1'h0;
	logic short_word = 1'h0;
	logic clk_en = 1'h1;
	logic ssi_clk;
	logic ssi_data;
	logic xfer;
	logic dir_rev;
	int n_fail = 0;
	int checks_done = 0;
	sae_encoder_port #(.DIR_SETTLE_CYC(18'h00010)) uut (.i_sys_clk(sys_clk), .i_rst_n(rst_n),
		.i_clk_en(clk_en), .i_ssi_clk(ssi_clk), .i_raw_pos(raw_pos), .i_special(special),
		.i_dir_sel_n(dir_sel_n), .i_gray_sel(gray_sel), .i_short_word(short_word),
		.o_ssi_data(ssi_data), .o_xfer_active(xfer), .o_dir_reversed(dir_rev));
	sae_ssi_master mst (.i_ssi_data(ssi_data), .o_ssi_clk(ssi_clk));
	initial forever #2.5 sys_clk = ~sys_clk;
	function automatic logic [24:0] exp_frame();
		logic [15:0] c;
		c = dir_sel_n ? ~raw_pos : raw_pos;
		if (gray_sel) c = c ^ (c >> 1);
		exp_frame = short_word ? {11'h000, c[15:3], special} : {8'h00, c, special};
	endfunction
	task automatic chk(input string nm, input logic [24:0] e, input logic [24:0] g);
		checks_done++;
		if (g !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic conclude();
		if (n_fail == 0 && checks_done > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// A short word that stops after 25 pulses leaves its last bit on the line
	task automatic wait_idle_line(input logic tail);
		repeat (3900) @(negedge sys_clk);
		chk("tail data", {24'h000000, tail}, ssi_data);
		chk("tail busy", 25'h1, xfer);
		repeat (150) @(negedge sys_clk);
		chk("idle data", 25'h1, ssi_data);
		chk("idle busy", 25'h0, xfer);
	endtask
	// Sized for the whole sequence with margin; a hang counts as a failure
	initial begin
		#450000;
		n_fail++;
		conclude();
	end
	initial begin
		logic [63:0] q;
		logic [24:0] f;
		repeat (4) @(negedge sys_clk);
		chk("reset data", 25'h1, ssi_data);
		rst_n = 1'h1;
		repeat (4) @(negedge sys_clk);
		foreach (rows[i]) begin
			{raw_pos, special, dir_sel_n, gray_sel, short_word} = rows[i][20:1];
			repeat (40) @(negedge sys_clk);
			chk("reversed", rows[i].rev, dir_rev);
			f = exp_frame();
			mst.burst(30, 1'h1, q);
			chk("word", f, q[29:5]);
			chk("after lsb", 25'h0, q[4:0]);
			wait_idle_line(1'h0);
		end
		// Ring mode: position moves mid-burst, the repeat must still show the first word
		f = exp_frame();
		fork
			mst.burst(50, 1'h1, q);
			begin
				repeat (2000) @(negedge sys_clk);
				raw_pos = 16'h5A3C;
			end
		join
		chk("ring first", f, q[49:25]);
		chk("ring again", f, q[24:0]);
		repeat (4300) @(negedge sys_clk);
		f = exp_frame();
		mst.burst(25, 1'h1, q);
		chk("before gap", f, q[24:0]);
		@(negedge sys_clk);
		raw_pos = 16'h7E81;
		repeat (4300) @(negedge sys_clk);
		f = exp_frame();
		mst.burst(25, 1'h0, q);
		chk("late pulse 26", f, q[24:0]);
		wait_idle_line(special);
		// Clock enable low freezes the monoflop, so the tail outlasts 20 us of wall time
		mst.burst(25, 1'h1, q);
		chk("frozen word", f, q[24:0]);
		repeat (1000) @(negedge sys_clk);
		clk_en = 1'h0;
		repeat (2000) @(negedge sys_clk);
		clk_en = 1'h1;
		repeat (2000) @(negedge sys_clk);
		chk("frozen busy", 25'h1, xfer);
		chk("frozen data", {24'h000000, special}, ssi_data);
		repeat (1100) @(negedge sys_clk);
		chk("thawed data", 25'h1, ssi_data);
		chk("thawed busy", 25'h0, xfer);
		conclude();
	end
endmodule
